// [shared/link_core_regs_map.svh]
`ifndef LINK_CORE_REGS_MAP_SVH
`define LINK_CORE_REGS_MAP_SVH

// byte addresses of the register group
`define ZONE_UPPER_OFFSET    32'h4000_0058
`define ZONE_LOWER_OFFSET    32'h4000_005C
`define ERROR_CAUSE_OFFSET   32'h4000_0060
`define PROFILING_OFFSET     32'h4000_0064
`define CORRELATOR_OFFSET    32'h4000_0070
`define RADIO_SELECT_OFFSET  32'h4000_0074
`define POWER_PHASE_OFFSET   32'h4000_0080

// reset values
`define ZONE_RESET           16'h0000
`define PROFILING_RESET      32'h0000_0000
`define CORRELATOR_RESET     32'h0000_2102
`define RADIO_SELECT_RESET   5'h00
`define ROUND_TRIP_RESET     7'h00
`define RX_POWERUP_RESET     8'hD2
`define TX_POWERDOWN_RESET   4'h3
`define TX_POWERUP_RESET     8'hD2

// field positions
`define DC_COMP_BIT          22
`define RADIO_SELECT_LSB     16
`define ROUND_TRIP_LSB       24
`define RX_POWERUP_LSB       16
`define TX_POWERDOWN_LSB     8
`define TX_POWERUP_LSB       0

// error cause bit positions
`define FORMAT_FAULT_BIT     11
`define NULL_TXPTR_FAULT_BIT 10
`define RADIO_MEM_FAULT_BIT  8
`define CHANMAP_FAULT_BIT    7
`define GAP_OVERRUN_BIT      6
`define RX_DECIPHER_BIT      5
`define ACCEPT_LIST_BIT      4
`define PREFETCH_FAULT_BIT   3
`define TX_DESC_FAULT_BIT    2
`define PKT_MEM_FAULT_BIT    1
`define TX_ENCIPHER_BIT      0

// prefetch fault after this many programmed entries in a row
`define PREFETCH_RUN_LIMIT   2'h3

// timing: one microsecond at the 4 ns system clock
`define US_NS                1000
`define CLK_PERIOD_NS        4
`define CYCLES_PER_US        (`US_NS / `CLK_PERIOD_NS)

`endif

// [shared/link_core_regs_pkg.sv]
package link_core_regs_pkg;

   // one register bus request, driven by the processor side
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [31:0] addr;
      logic [31:0] wdata;
   } bus_req_t;

   // observations from the link-layer engine, same clock domain
   typedef struct packed {
      logic        format_check;
      logic        format_illegal;
      logic        tx_ptr_load;
      logic [15:0] struct_tx_pointer;
      logic        radio_mem_late;
      logic        hop_start;
      logic [36:0] struct_channel_map;
      logic [5:0]  good_channel_count;
      logic        gap_overrun;
      logic        rx_decipher_late;
      logic        accept_list_late;
      logic        exch_entry_fetch;
      logic        exch_entry_programmed;
      logic        desc_fetch;
      logic        descriptor_sent_flag;
      logic        pkt_mem_late;
      logic        tx_encipher_late;
   } link_events_t;

   // static radio controls handed to the radio
   typedef struct packed {
      logic       dc_comp_path_enable;
      logic [4:0] extended_radio_select;
      logic [6:0] round_trip_latency;
   } radio_ctrl_t;

   // power phase start pulses
   typedef struct packed {
      logic tx_up_start;
      logic rx_up_start;
      logic tx_down_start;
   } phase_req_t;

   // power phase status
   typedef struct packed {
      logic tx_up_busy;
      logic tx_up_done;
      logic rx_up_busy;
      logic rx_up_done;
      logic tx_down_busy;
      logic tx_down_done;
   } phase_stat_t;

   // state of the register group
   typedef struct packed {
      logic [15:0] zone_lower_bound;
      logic [15:0] zone_upper_bound;
      logic [11:0] fault;
      logic [31:0] profiling_value;
      logic        dc_comp_path_enable;
      logic [4:0]  extended_radio_select;
      logic [6:0]  round_trip_latency;
      logic [7:0]  rx_powerup_time;
      logic [3:0]  tx_powerdown_extension;
      logic [7:0]  tx_powerup_time;
      logic [31:0] rd_data;
      logic [1:0]  prefetch_run;
   } regs_state_t;

   // state of one power phase timer
   typedef struct packed {
      logic       busy;
      logic       done;
      logic [7:0] us_left;
      logic [7:0] prescale;
   } timer_state_t;

endpackage

// [rtl/radio_phase_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "link_core_regs_map.svh"

// counts a power phase of len_us microseconds after a start pulse
module radio_phase_timer (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       start,
   input  wire logic [7:0] len_us,
   output logic            busy,
   output logic            done
);
   import link_core_regs_pkg::*;

   localparam logic [7:0] PRESCALE_TOP = 8'(`CYCLES_PER_US - 1);

   timer_state_t s_q;  // registered state
   timer_state_t s_d;  // next state

   // next state: a new start always restarts the phase
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (start) begin
         // zero length finishes at once, with no busy cycle
         s_d.busy     = (len_us != 8'h00);
         s_d.done     = (len_us == 8'h00);
         s_d.us_left  = len_us;
         s_d.prescale = PRESCALE_TOP;
      end else if (s_q.busy) begin
         if (s_q.prescale == 8'h00) begin
            s_d.prescale = PRESCALE_TOP;
            s_d.us_left  = s_q.us_left - 8'h01;
            if (s_q.us_left == 8'h01) begin
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
            end
         end else begin
            s_d.prescale = s_q.prescale - 8'h01;
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign busy = s_q.busy;
   assign done = s_q.done;

endmodule
`default_nettype wire

// [rtl/link_core_error_radio_timing_regs.sv]
// Functional notes
// - zone lower bound, 16 bits, upper zero
// - zone upper bound, 16 bits read/write
// - bit 11 flags illegal structure format
// - bit 10 flags zero transmit pointer
// - bit 8 flags late radio memory access
// - bit 7 flags channel map count mismatch
// - bit 6 flags interframe gap overrun
// - bit 5 flags late receive decryption
// - bit 4 flags accept list parse timeout
// - bit 3 flags three programmed entries
// - bit 2 flags descriptor without sent flag
// - bit 1 flags late packet memory access
// - bit 0 flags late encryption; one means error
// - profiling word mirrored to diagnostic port
// - round trip latency field bits 30:24
// - rx power-up time, resets to 210
// - tx power-down extension, resets to 3
// - tx power-up time, resets to 210
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "link_core_regs_map.svh"

module link_core_error_radio_timing_regs (
   input  wire logic                            sys_clk,
   input  wire logic                            rst,
   input  wire link_core_regs_pkg::bus_req_t    bus_req,
   output logic [31:0]                          rd_data,
   input  wire link_core_regs_pkg::link_events_t events,
   input  wire link_core_regs_pkg::phase_req_t  phase_req,
   output link_core_regs_pkg::phase_stat_t      phase_stat,
   output link_core_regs_pkg::radio_ctrl_t      radio_ctrl,
   output logic [31:0]                          diag_profiling,
   output logic [11:0]                          fault_status,
   output logic [15:0]                          zone_lower_bound,
   output logic [15:0]                          zone_upper_bound
);
   import link_core_regs_pkg::*;

   regs_state_t s_q;          // registered state
   regs_state_t s_d;          // next state
   logic [11:0] fault_set;    // fault events seen this cycle
   logic [5:0]  map_ones;     // ones in the channel map
   logic [31:0] rd_mux;       // read value before the output flop
   logic        hit_lower;    // address decode terms
   logic        hit_upper;
   logic        hit_fault;
   logic        hit_prof;
   logic        hit_corr;
   logic        hit_select;
   logic        hit_power;

   // counts the ones of the 37-channel map
   function automatic logic [5:0] count_ones(input logic [36:0] map);
      logic [5:0] n;
      n = 6'h00;
      for (int i = 0; i < 37; i++) begin
         n = n + {5'h00, map[i]};
      end
      return n;
   endfunction

   assign map_ones = count_ones(events.struct_channel_map);

   // address decode; full 32-bit compare so aliases read as unmapped
   assign hit_lower  = (bus_req.addr == `ZONE_LOWER_OFFSET);
   assign hit_upper  = (bus_req.addr == `ZONE_UPPER_OFFSET);
   assign hit_fault  = (bus_req.addr == `ERROR_CAUSE_OFFSET);
   assign hit_prof   = (bus_req.addr == `PROFILING_OFFSET);
   assign hit_corr   = (bus_req.addr == `CORRELATOR_OFFSET);
   assign hit_select = (bus_req.addr == `RADIO_SELECT_OFFSET);
   assign hit_power  = (bus_req.addr == `POWER_PHASE_OFFSET);

   // fault detection from the engine's observations
   always_comb begin
      fault_set = 12'h000;
      // format checked and found illegal
      fault_set[`FORMAT_FAULT_BIT] = events.format_check
                                   & events.format_illegal;
      // a zero pointer is a setup fault of software
      fault_set[`NULL_TXPTR_FAULT_BIT] = events.tx_ptr_load
         & (events.struct_tx_pointer == 16'h0000);
      fault_set[`RADIO_MEM_FAULT_BIT] = events.radio_mem_late;
      // only compared when hopping starts; the map may change otherwise
      fault_set[`CHANMAP_FAULT_BIT] = events.hop_start
         & (map_ones != events.good_channel_count);
      fault_set[`GAP_OVERRUN_BIT] = events.gap_overrun;
      fault_set[`RX_DECIPHER_BIT] = events.rx_decipher_late;
      fault_set[`ACCEPT_LIST_BIT] = events.accept_list_late;
      // third programmed entry in a row, counter holds the two before
      fault_set[`PREFETCH_FAULT_BIT] = events.exch_entry_fetch
         & events.exch_entry_programmed
         & (s_q.prefetch_run == (`PREFETCH_RUN_LIMIT - 2'h1));
      fault_set[`TX_DESC_FAULT_BIT] = events.desc_fetch
         & ~events.descriptor_sent_flag;
      fault_set[`PKT_MEM_FAULT_BIT] = events.pkt_mem_late;
      fault_set[`TX_ENCIPHER_BIT] = events.tx_encipher_late;
   end

   // read multiplexer; unmapped addresses and reserved bits give zero, except the correlator's fixed low pattern
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_lower) begin
         rd_mux[15:0] = s_q.zone_lower_bound;
      end else if (hit_upper) begin
         rd_mux[15:0] = s_q.zone_upper_bound;
      end else if (hit_fault) begin
         rd_mux[11:0] = s_q.fault;
      end else if (hit_prof) begin
         rd_mux = s_q.profiling_value;
      end else if (hit_corr) begin
         // reserved low bits keep their fixed pattern
         rd_mux = `CORRELATOR_RESET;
         rd_mux[`DC_COMP_BIT] = s_q.dc_comp_path_enable;
      end else if (hit_select) begin
         rd_mux[`RADIO_SELECT_LSB +: 5] = s_q.extended_radio_select;
      end else if (hit_power) begin
         rd_mux[`ROUND_TRIP_LSB +: 7]   = s_q.round_trip_latency;
         rd_mux[`RX_POWERUP_LSB +: 8]   = s_q.rx_powerup_time;
         rd_mux[`TX_POWERDOWN_LSB +: 4] = s_q.tx_powerdown_extension;
         rd_mux[`TX_POWERUP_LSB +: 8]   = s_q.tx_powerup_time;
      end
   end

   // next state of the whole register group
   always_comb begin
      s_d = s_q;
      // faults only ever set; nothing but reset clears them
      s_d.fault = s_q.fault | fault_set;
      // run of programmed entries, broken by an empty one
      if (events.exch_entry_fetch) begin
         if (!events.exch_entry_programmed) begin
            s_d.prefetch_run = 2'h0;
         end else if (s_q.prefetch_run != `PREFETCH_RUN_LIMIT) begin
            s_d.prefetch_run = s_q.prefetch_run + 2'h1;
         end
      end
      // read data stand for exactly one cycle after the strobe
      s_d.rd_data = bus_req.rd ? rd_mux : 32'h0000_0000;
      // writes; the fault word ignores them
      if (bus_req.wr) begin
         if (hit_lower) begin
            s_d.zone_lower_bound = bus_req.wdata[15:0];
         end
         if (hit_upper) begin
            s_d.zone_upper_bound = bus_req.wdata[15:0];
         end
         if (hit_prof) begin
            s_d.profiling_value = bus_req.wdata;
         end
         if (hit_corr) begin
            // stored as written; software must keep it clear
            s_d.dc_comp_path_enable = bus_req.wdata[`DC_COMP_BIT];
         end
         if (hit_select) begin
            // no check here: software must write the mandated pattern
            s_d.extended_radio_select =
               bus_req.wdata[`RADIO_SELECT_LSB +: 5];
         end
         if (hit_power) begin
            s_d.round_trip_latency =
               bus_req.wdata[`ROUND_TRIP_LSB +: 7];
            s_d.rx_powerup_time =
               bus_req.wdata[`RX_POWERUP_LSB +: 8];
            s_d.tx_powerdown_extension =
               bus_req.wdata[`TX_POWERDOWN_LSB +: 4];
            s_d.tx_powerup_time =
               bus_req.wdata[`TX_POWERUP_LSB +: 8];
         end
      end
   end

   // state register with documented reset values
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_q                        <= '0;
         s_q.zone_lower_bound       <= `ZONE_RESET;
         s_q.zone_upper_bound       <= `ZONE_RESET;
         s_q.profiling_value        <= `PROFILING_RESET;
         s_q.extended_radio_select  <= `RADIO_SELECT_RESET;
         s_q.round_trip_latency     <= `ROUND_TRIP_RESET;
         s_q.rx_powerup_time        <= `RX_POWERUP_RESET;
         s_q.tx_powerdown_extension <= `TX_POWERDOWN_RESET;
         s_q.tx_powerup_time        <= `TX_POWERUP_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // power phase timers; a setting change affects the next phase only
   radio_phase_timer tx_up_timer (
      .sys_clk (sys_clk),
      .rst     (rst),
      .start   (phase_req.tx_up_start),
      .len_us  (s_q.tx_powerup_time),
      .busy    (phase_stat.tx_up_busy),
      .done    (phase_stat.tx_up_done)
   );

   radio_phase_timer rx_up_timer (
      .sys_clk (sys_clk),
      .rst     (rst),
      .start   (phase_req.rx_up_start),
      .len_us  (s_q.rx_powerup_time),
      .busy    (phase_stat.rx_up_busy),
      .done    (phase_stat.rx_up_done)
   );

   // the extension is the whole added tail after power-down starts
   radio_phase_timer tx_down_timer (
      .sys_clk (sys_clk),
      .rst     (rst),
      .start   (phase_req.tx_down_start),
      .len_us  ({4'h0, s_q.tx_powerdown_extension}),
      .busy    (phase_stat.tx_down_busy),
      .done    (phase_stat.tx_down_done)
   );

   // outputs straight from the state flops
   assign rd_data                          = s_q.rd_data;
   assign diag_profiling                   = s_q.profiling_value;
   assign fault_status                     = s_q.fault;
   assign zone_lower_bound                 = s_q.zone_lower_bound;
   assign zone_upper_bound                 = s_q.zone_upper_bound;
   assign radio_ctrl.dc_comp_path_enable   = s_q.dc_comp_path_enable;
   assign radio_ctrl.extended_radio_select = s_q.extended_radio_select;
   assign radio_ctrl.round_trip_latency    = s_q.round_trip_latency;

endmodule
`default_nettype wire

// [verification/link_core_regs_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "link_core_regs_map.svh"

// port-level watcher of the register group
module link_core_regs_checker
   import link_core_regs_pkg::*;
(
   input wire logic                             sys_clk,
   input wire logic                             rst,
   input wire link_core_regs_pkg::bus_req_t     bus_req,
   input wire logic [31:0]                      rd_data,
   input wire link_core_regs_pkg::link_events_t events,
   input wire link_core_regs_pkg::phase_req_t   phase_req,
   input wire link_core_regs_pkg::phase_stat_t  phase_stat,
   input wire link_core_regs_pkg::radio_ctrl_t  radio_ctrl,
   input wire logic [31:0]                      diag_profiling,
   input wire logic [11:0]                      fault_status,
   input wire logic [15:0]                      zone_lower_bound,
   input wire logic [15:0]                      zone_upper_bound
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // a read of the cause word returns what the flags showed when it was taken
   a_fault_read: assert property (bus_req.rd && bus_req.addr == `ERROR_CAUSE_OFFSET |=>
      rd_data == {20'h0_0000, $past(fault_status)}) else $error("fault word read wrong");
   // no flag may drop outside reset; first edge after reset is skipped
   a_fault_sticky: assert property (!$past(rst) |->
      ($past(fault_status) & ~fault_status) == 12'h000) else $error("fault flag dropped");
   a_format_flag: assert property (events.format_check && events.format_illegal |=>
      fault_status[11]) else $error("format fault missed");
   a_null_pointer: assert property (events.tx_ptr_load && events.struct_tx_pointer == 0 |=>
      fault_status[10]) else $error("null pointer missed");
   a_chanmap_count: assert property (events.hop_start &&
      $countones(events.struct_channel_map) != events.good_channel_count |=> fault_status[7])
      else $error("channel count fault missed");
   a_desc_unsent: assert property (events.desc_fetch && !events.descriptor_sent_flag |=>
      fault_status[2]) else $error("descriptor fault missed");
   a_gap_overrun: assert property (events.gap_overrun |=> fault_status[6])
      else $error("gap overrun missed");
   a_profile_mirror: assert property (bus_req.wr && bus_req.addr == `PROFILING_OFFSET |=>
      diag_profiling == $past(bus_req.wdata)) else $error("profiling not mirrored");
   a_lower_write: assert property (bus_req.wr && bus_req.addr == `ZONE_LOWER_OFFSET |=>
      zone_lower_bound == $past(bus_req.wdata[15:0])) else $error("lower bound not stored");
   a_upper_write: assert property (bus_req.wr && bus_req.addr == `ZONE_UPPER_OFFSET |=>
      zone_upper_bound == $past(bus_req.wdata[15:0])) else $error("upper bound not stored");
   // busy must fall on the very cycle the done pulse shows
   a_done_ends_busy: assert property (phase_stat.tx_down_done |->
      !phase_stat.tx_down_busy ##1 !phase_stat.tx_down_done) else $error("busy overlaps done");

   c_gap: cover property (events.gap_overrun);
   c_down_start: cover property (phase_req.tx_down_start);
   c_down_done: cover property (phase_stat.tx_down_done);
   c_select: cover property (radio_ctrl.extended_radio_select == 5'h03);
endmodule

bind link_core_error_radio_timing_regs link_core_regs_checker link_core_regs_checker_inst (
   .sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data), .events(events),
   .phase_req(phase_req), .phase_stat(phase_stat), .radio_ctrl(radio_ctrl),
   .diag_profiling(diag_profiling), .fault_status(fault_status),
   .zone_lower_bound(zone_lower_bound), .zone_upper_bound(zone_upper_bound));

`default_nettype wire

// [verification/tb_link_core_error_radio_timing_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "link_core_regs_map.svh"

module tb_link_core_error_radio_timing_regs
   import link_core_regs_pkg::*;
;
   logic         sys_clk = 1'b0;
   logic         rst = 1'b1;
   bus_req_t     bus_req = '0;
   link_events_t events = '0;
   phase_req_t   phase_req = '0;
   phase_stat_t  phase_stat;
   radio_ctrl_t  radio_ctrl;
   logic [31:0]  rd_data;
   logic [31:0]  diag_profiling;
   logic [11:0]  fault_status;
   logic [15:0]  zone_lower_bound;
   logic [15:0]  zone_upper_bound;
   int           miscompares = 0;
   int           checked = 0;
   int           cycles = 0;
   int           bits [10] = '{11, 10, 8, 7, 6, 5, 4, 2, 1, 0};
   // word table: upper, lower, causes, profiling, correlator, select, power, unmapped
   logic [31:0]  reg_addr [8] = '{`ZONE_UPPER_OFFSET, `ZONE_LOWER_OFFSET, `ERROR_CAUSE_OFFSET,
      `PROFILING_OFFSET, `CORRELATOR_OFFSET, `RADIO_SELECT_OFFSET, `POWER_PHASE_OFFSET,
      32'h4000_0068};
   // writable bits; anything outside keeps its model value
   logic [31:0]  reg_mask [8] = '{32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_0000, 32'hFFFF_FFFF,
      32'h0040_0000, 32'h001F_0000, 32'h7FFF_0FFF, 32'h0000_0000};
   logic [31:0]  model [8];

   link_core_error_radio_timing_regs link_core_error_radio_timing_regs_inst (
      .sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data), .events(events),
      .phase_req(phase_req), .phase_stat(phase_stat), .radio_ctrl(radio_ctrl),
      .diag_profiling(diag_profiling), .fault_status(fault_status),
      .zone_lower_bound(zone_lower_bound), .zone_upper_bound(zone_upper_bound));

   // 4 ns period
   always #2 sys_clk = ~sys_clk;

   // hang guard, far above the few thousand cycles the run needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic do_reset();
      // a mid-run reset is raised on a rising edge like every other input
      if (!rst) begin
         @(posedge sys_clk);
      end
      rst <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      model = '{default: 32'h0000_0000};
      model[4] = 32'h0000_2102;
      model[6] = 32'h00D2_03D2;
   endtask

   // write is left standing; the next read replaces it on the following edge
   task automatic wr(input int i, input logic [31:0] d);
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: reg_addr[i], wdata: d};
      model[i] = (d & reg_mask[i]) | (model[i] & ~reg_mask[i]);
   endtask

   task automatic rd(input int i);
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: reg_addr[i], wdata: 32'h0000_0000};
      @(posedge sys_clk);
      bus_req <= '0;
      @(negedge sys_clk);
      chk(rd_data, model[i]);
      // read data stand for one cycle only, then fall back to zero
      @(negedge sys_clk);
      chk(rd_data, 32'h0000_0000);
   endtask

   task automatic chk_out();
      chk({16'h0000, zone_upper_bound}, model[0]);
      chk({16'h0000, zone_lower_bound}, model[1]);
      chk(diag_profiling, model[3]);
      chk({19'h0_0000, radio_ctrl}, {19'h0_0000, model[4][22], model[5][20:16],
         model[6][30:24]});
   endtask

   // i: 0 tx power-down, 1 rx power-up, 2 tx power-up
   task automatic phase(input int i, input int len);
      int n;
      n = 1;
      @(posedge sys_clk);
      phase_req <= phase_req_t'(3'h1 << i);
      @(posedge sys_clk);
      phase_req <= '0;
      @(negedge sys_clk);
      chk(32'(phase_stat[2*i+1]), 32'(len != 0));
      while (phase_stat[2*i] !== 1'b1 && n < 60000) begin
         @(negedge sys_clk);
         n++;
      end
      // n is 1 one cycle after the start is taken; done lands 250 cycles per microsecond later
      chk(n, (len == 0) ? 1 : len * 250 + 1);
   endtask

   // one-cycle event; bad selects the faulty flavour of it
   task automatic fire(input int k, input logic bad);
      link_events_t e;
      logic [36:0]  map;
      e = '0;
      map = 37'({$urandom, $urandom});
      case (k)
         11: begin
            e.format_check = 1'b1;
            e.format_illegal = bad;
         end
         10: begin
            e.tx_ptr_load = 1'b1;
            e.struct_tx_pointer = bad ? 16'h0000 : 16'(($urandom % 65535) + 1);
         end
         7: begin
            e.hop_start = 1'b1;
            e.struct_channel_map = map;
            e.good_channel_count = 6'($countones(map)) + 6'(bad);
         end
         3: begin
            e.exch_entry_fetch = 1'b1;
            e.exch_entry_programmed = bad;
         end
         2: begin
            e.desc_fetch = 1'b1;
            e.descriptor_sent_flag = !bad;
         end
         8: e.radio_mem_late = bad;
         6: e.gap_overrun = bad;
         5: e.rx_decipher_late = bad;
         4: e.accept_list_late = bad;
         1: e.pkt_mem_late = bad;
         default: e.tx_encipher_late = bad;
      endcase
      @(posedge sys_clk);
      events <= e;
      @(posedge sys_clk);
      events <= '0;
      @(negedge sys_clk);
   endtask

   task automatic conclude();
      $display("counts: checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      void'($urandom(31));
      do_reset();
      for (int i = 0; i < 8; i++) rd(i);
      chk_out();
      phase(0, 3);
      $display("test reset_values done");
      // random data to every word, the read-only and unmapped ones too
      repeat (4) for (int i = 0; i < 8; i++) begin
         wr(i, $urandom);
         rd(i);
         chk_out();
      end
      wr(4, 32'h0000_0000);
      rd(4);
      wr(5, 32'h0003_0000);
      rd(5);
      wr(6, 32'h0502_0100);
      rd(6);
      chk_out();
      phase(0, 1);
      phase(1, 2);
      phase(2, 0);
      // a short tx power-up phase, so its busy level is seen as well
      wr(6, 32'h0000_0001);
      rd(6);
      phase(2, 1);
      $display("test registers_and_timers done");
      foreach (bits[j]) begin
         fire(bits[j], 1'b0);
         chk({20'h0_0000, fault_status}, model[2]);
         fire(bits[j], 1'b1);
         model[2][bits[j]] = 1'b1;
         chk({20'h0_0000, fault_status}, model[2]);
      end
      // an unprogrammed fetch breaks the run of programmed entries
      fire(3, 1'b1);
      fire(3, 1'b1);
      fire(3, 1'b0);
      fire(3, 1'b1);
      fire(3, 1'b1);
      chk({20'h0_0000, fault_status}, model[2]);
      fire(3, 1'b1);
      model[2][3] = 1'b1;
      chk({20'h0_0000, fault_status}, model[2]);
      rd(2);
      $display("test fault_flags done");
      do_reset();
      rd(2);
      chk_out();
      $display("test second_reset done");
      conclude();
   end
endmodule

`default_nettype wire
